// ---- icc_defines.svh ----
// Purpose: constants for the input capture control block
// Assumes: 16-bit register port, one word per offset
// Notes: control at index 0, data read at 1, status/mask at 2/3
// Operation
// - idle-stop bit halts channel during idle
// - timebase select picks channel clock source
// - captures-per-interrupt sets interrupt rate
// - rate field ignored in modes 001, 111
// - overflow set on capture into full buffer
// - not-empty bit shows unread captured value
// - status bits hardware-owned, zero after reset
// - mode 111 rising-edge wake interrupt only
// - mode 110 behaves as disabled
// - modes 101/100 capture every 16th/4th rise
// - mode 011 captures every falling edge
// - mode 001 captures both edges, interrupts each
// - mode 000 switches channel off
// - unused control bits read zero
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH
`define ICC_ADDR_CTRL     4'h0
`define ICC_ADDR_DATA     4'h1
`define ICC_ADDR_IRQ_STAT 4'h2
`define ICC_ADDR_IRQ_MASK 4'h3
`define ICC_BIT_IDLE      13
`define ICC_BIT_TSEL_LO   10
`define ICC_BIT_RATE_LO   5
`define ICC_BIT_OVF       4
`define ICC_BIT_BNE       3
`define ICC_CTRL_WMASK    16'h3C67
`define ICC_CTRL_RESET    16'h0000
`endif

// ---- icc_pkg.sv ----
// Purpose: types for the input capture control block
// Assumes: nothing beyond the defines header
// Notes: mode codes are the control field encodings
package icc_pkg;
	typedef enum logic [2:0]
	{
		ICC_MODE_OFF    = 3'h0,
		ICC_MODE_BOTH   = 3'h1,
		ICC_MODE_RISE   = 3'h2,
		ICC_MODE_FALL   = 3'h3,
		ICC_MODE_RISE4  = 3'h4,
		ICC_MODE_RISE16 = 3'h5,
		ICC_MODE_UNUSED = 3'h6,
		ICC_MODE_WAKE   = 3'h7
	} icc_mode_e;
	typedef struct packed
	{
		logic        idle_stop_select;
		logic [2:0]  timebase_select;
		logic [1:0]  captures_per_interrupt;
		icc_mode_e   capture_mode_select;
	} icc_ctrl_s;
	typedef struct packed
	{
		logic wake;
		logic overflow;
		logic capture;
	} icc_irq_s;
endpackage

// ---- icc_top.sv ----
// Purpose: one input capture channel with control, fifo and interrupts
// Assumes: timer values come from logic on core_clk; capture pin is async
// Notes: status sticky bits clear on read; set beats the read clear
//
// Our own choices: the address map and the plain strobed port.
`include "icc_defines.svh"
module icc_top #(
	parameter int DEPTH = 4,
	parameter int TW    = 16
) (
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire logic [3:0]    reg_addr,
	input  wire logic [15:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [15:0]   reg_rdata,
	input  wire logic          capture_channel,
	input  wire logic          cpu_idle,
	input  wire logic          cpu_sleep,
	input  wire logic [TW-1:0] peripheral_clock,
	input  wire logic [TW-1:0] timer_one_clock,
	input  wire logic [TW-1:0] timer_two_clock,
	input  wire logic [TW-1:0] timer_three_clock,
	input  wire logic [TW-1:0] timer_four_clock,
	input  wire logic [TW-1:0] timer_five_clock,
	output logic               capture_event_q,
	output logic               irq_q
);
	localparam int AW = $clog2(DEPTH);
	icc_pkg::icc_ctrl_s ctrl_q;
	logic               sync1_q;
	logic               sync2_q;
	logic               pin_q;
	logic [TW-1:0]      mem_q [DEPTH];
	logic [AW-1:0]      wptr_q;
	logic [AW-1:0]      rptr_q;
	logic [AW:0]        count_q;
	logic               ovf_q;
	logic [3:0]         pre_q;
	logic [1:0]         rate_cnt_q;
	icc_pkg::icc_irq_s  stat_q;
	icc_pkg::icc_irq_s  mask_q;
	logic               rise;
	logic               fall;
	logic               active;
	logic               edge_hit;
	logic               cap;
	logic               fifo_full;
	logic               pop;
	logic               push;
	logic               rate_done;
	logic               wake_hit;
	logic [TW-1:0]      tb_val;
	logic [15:0]        ctrl_rd;
	logic [15:0]        rdata_d;

	// two flops before anything looks at the pin
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			pin_q   <= 1'b0;
		end
		else
		begin
			sync1_q <= capture_channel;
			sync2_q <= sync1_q;
			pin_q   <= sync2_q;
		end
	end

	assign rise = sync2_q & ~pin_q;
	assign fall = ~sync2_q & pin_q;

	always_comb
	begin
		case (ctrl_q.timebase_select)
			3'h7:    tb_val = peripheral_clock;
			3'h4:    tb_val = timer_one_clock;
			3'h3:    tb_val = timer_five_clock;
			3'h2:    tb_val = timer_four_clock;
			3'h1:    tb_val = timer_two_clock;
			3'h0:    tb_val = timer_three_clock;
			default: tb_val = '0;
		endcase
	end

	// idle halts capture only when asked; sleep always halts capture and the prescaler
	assign active = !(cpu_sleep || (cpu_idle && ctrl_q.idle_stop_select));

	always_comb
	begin
		case (ctrl_q.capture_mode_select)
			icc_pkg::ICC_MODE_BOTH:   edge_hit = rise | fall;
			icc_pkg::ICC_MODE_RISE:   edge_hit = rise;
			icc_pkg::ICC_MODE_FALL:   edge_hit = fall;
			icc_pkg::ICC_MODE_RISE4:  edge_hit = rise && (pre_q[1:0] == 2'h3);
			icc_pkg::ICC_MODE_RISE16: edge_hit = rise && (pre_q == 4'hF);
			default:                  edge_hit = 1'b0;
		endcase
	end

	assign cap       = edge_hit && active;
	assign fifo_full = (count_q == (AW+1)'(DEPTH));
	assign push      = cap && !fifo_full;
	assign pop       = reg_rd && (reg_addr == `ICC_ADDR_DATA) && (count_q != '0);
	// wake mode ignores idle/sleep gating: it exists to fire there
	assign wake_hit  = (ctrl_q.capture_mode_select == icc_pkg::ICC_MODE_WAKE) && rise;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pre_q <= 4'h0;
		else if (ctrl_q.capture_mode_select != icc_pkg::ICC_MODE_RISE4 &&
			ctrl_q.capture_mode_select != icc_pkg::ICC_MODE_RISE16)
			pre_q <= 4'h0;
		else if (rise && active)
			pre_q <= pre_q + 4'h1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= '0;
		else if (reg_wr && reg_addr == `ICC_ADDR_CTRL)
		begin
			ctrl_q.idle_stop_select       <= reg_wdata[`ICC_BIT_IDLE];
			ctrl_q.timebase_select        <= reg_wdata[`ICC_BIT_TSEL_LO +: 3];
			ctrl_q.captures_per_interrupt <= reg_wdata[`ICC_BIT_RATE_LO +: 2];
			ctrl_q.capture_mode_select    <= icc_pkg::icc_mode_e'(reg_wdata[2:0]);
		end
	end

	// fifo storage, no reset needed on data words
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_q[wptr_q] <= tb_val;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + AW'(1);
			if (pop)
				rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + AW'(1);
			if (push && !pop)
				count_q <= count_q + (AW+1)'(1);
			else if (pop && !push)
				count_q <= count_q - (AW+1)'(1);
		end
	end

	// overflow stays until buffer drains empty; mode off also clears it
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ovf_q <= 1'b0;
		else if (cap && fifo_full)
			ovf_q <= 1'b1;
		else if (ctrl_q.capture_mode_select == icc_pkg::ICC_MODE_OFF || count_q == '0)
			ovf_q <= 1'b0;
	end

	always_comb
	begin
		case (ctrl_q.capture_mode_select)
			icc_pkg::ICC_MODE_BOTH: rate_done = 1'b1;
			default:                rate_done = (rate_cnt_q == ctrl_q.captures_per_interrupt);
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rate_cnt_q <= 2'h0;
		else if (reg_wr && reg_addr == `ICC_ADDR_CTRL)
			rate_cnt_q <= 2'h0;
		else if (cap)
			rate_cnt_q <= rate_done ? 2'h0 : rate_cnt_q + 2'h1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			capture_event_q <= 1'b0;
		else
			capture_event_q <= (cap && rate_done) || wake_hit;
	end

	// sticky status: a new event in the reading cycle survives the clear
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			stat_q <= '0;
		else
		begin
			if (reg_rd && reg_addr == `ICC_ADDR_IRQ_STAT)
				stat_q <= '0;
			if (cap && rate_done)
				stat_q.capture <= 1'b1;
			if (cap && fifo_full)
				stat_q.overflow <= 1'b1;
			if (wake_hit)
				stat_q.wake <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			mask_q <= '0;
		else if (reg_wr && reg_addr == `ICC_ADDR_IRQ_MASK)
			mask_q <= reg_wdata[2:0];
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= |(stat_q & mask_q);
	end

	always_comb
	begin
		ctrl_rd = 16'h0000;
		ctrl_rd[`ICC_BIT_IDLE]          = ctrl_q.idle_stop_select;
		ctrl_rd[`ICC_BIT_TSEL_LO +: 3]  = ctrl_q.timebase_select;
		ctrl_rd[`ICC_BIT_RATE_LO +: 2]  = ctrl_q.captures_per_interrupt;
		ctrl_rd[`ICC_BIT_OVF]           = ovf_q;
		ctrl_rd[`ICC_BIT_BNE]           = (count_q != '0);
		ctrl_rd[2:0]                    = ctrl_q.capture_mode_select;
	end

	always_comb
	begin
		rdata_d = 16'h0000;
		case (reg_addr)
			`ICC_ADDR_CTRL:     rdata_d = ctrl_rd;
			`ICC_ADDR_DATA:     rdata_d = (count_q != '0) ? 16'(mem_q[rptr_q]) : 16'h0000;
			`ICC_ADDR_IRQ_STAT: rdata_d = {13'h0000, stat_q};
			`ICC_ADDR_IRQ_MASK: rdata_d = {13'h0000, mask_q};
			default:            rdata_d = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= rdata_d;
		else
			reg_rdata <= 16'h0000;
	end

	chk_ovf_on_full: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cap && fifo_full) |=> ovf_q)
		else $error("overflow not flagged");
	chk_bne_tracks: assert property (@(posedge core_clk) disable iff (!rst_n)
		(push && count_q == '0) |=> ctrl_rd[`ICC_BIT_BNE])
		else $error("not-empty missing after push");
	chk_unused_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ctrl_rd & 16'hC380) == 16'h0000)
		else $error("unused control bits nonzero");
	chk_off_no_cap: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ctrl_q.capture_mode_select == icc_pkg::ICC_MODE_OFF) |-> !cap)
		else $error("capture while off");
	chk_unused_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ctrl_q.capture_mode_select == icc_pkg::ICC_MODE_UNUSED) |=> !capture_event_q)
		else $error("event in unused mode");
	chk_idle_halt: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cpu_idle && ctrl_q.idle_stop_select) |-> !push)
		else $error("capture during idle stop");
	chk_both_each: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cap && ctrl_q.capture_mode_select == icc_pkg::ICC_MODE_BOTH) |=> capture_event_q)
		else $error("both-edge capture without event");
	chk_fall_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ctrl_q.capture_mode_select == icc_pkg::ICC_MODE_FALL && cap) |-> $fell(sync2_q))
		else $error("falling mode took non-falling edge");
	chk_rate_every: assert property (@(posedge core_clk) disable iff (!rst_n)
		(cap && ctrl_q.captures_per_interrupt == 2'h0) |=> capture_event_q)
		else $error("rate 00 missed event");
	chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
		|(stat_q & mask_q) |=> irq_q)
		else $error("irq not raised");
	cov_overflow: cover property (@(posedge core_clk) disable iff (!rst_n) cap && fifo_full);
	cov_wake: cover property (@(posedge core_clk) disable iff (!rst_n) wake_hit);
	cov_rise16: cover property (@(posedge core_clk) disable iff (!rst_n)
		cap && ctrl_q.capture_mode_select == icc_pkg::ICC_MODE_RISE16);
	cov_pop: cover property (@(posedge core_clk) disable iff (!rst_n) pop);
endmodule

// ---- icc_src_model.sv ----
// Purpose: timebase sources seen by the capture channel
// Assumes: sources are frozen so a captured value is predictable
// Notes: each source has its own value so a wrong select shows
module icc_src_model #(
	parameter int TW = 16
) (
	input  wire logic          core_clk,
	output logic      [TW-1:0] peripheral_clock,
	output logic      [TW-1:0] timer_one_clock,
	output logic      [TW-1:0] timer_two_clock,
	output logic      [TW-1:0] timer_three_clock,
	output logic      [TW-1:0] timer_four_clock,
	output logic      [TW-1:0] timer_five_clock
);
	timeunit 1ns;
	timeprecision 1ps;
	// frozen counters: a running one would tie checks to sync latency
	assign peripheral_clock  = TW'(16'h7777);
	assign timer_one_clock   = TW'(16'h1111);
	assign timer_two_clock   = TW'(16'h2222);
	assign timer_three_clock = TW'(16'h3333);
	assign timer_four_clock  = TW'(16'h4444);
	assign timer_five_clock  = TW'(16'h5555);
endmodule

// ---- tb.sv ----
// Purpose: self-checking bench for the capture channel
// Assumes: read data sampled one cycle after the strobe
// Notes: each pin change is given 5 cycles to pass the synchroniser
`include "icc_defines.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        capture_channel = 1'b0;
	logic        cpu_idle = 1'b0;
	logic        cpu_sleep = 1'b0;
	logic [15:0] src_p, src_1, src_2, src_3, src_4, src_5;
	logic        capture_event_q;
	logic        irq_q;
	logic [15:0] rv;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          ev_cnt = 0;
	logic [2:0]  ts[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h5, 3'h6};
	logic [15:0] tv[8] = '{16'h3333, 16'h2222, 16'h4444, 16'h5555, 16'h1111, 16'h7777, 16'h0000, 16'h0000};
	logic [15:0] cv[15] = '{16'h0001, 16'h0061, 16'h0002, 16'h0022, 16'h0042, 16'h0062, 16'h0003,
		16'h0004, 16'h0005, 16'h0006, 16'h0000, 16'h2002, 16'h0002, 16'h0002, 16'h0067};
	logic [1:0]  pw[15] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
		2'h2, 2'h1, 2'h2, 2'h0};
	int          ex[15] = '{32, 32, 16, 8, 5, 4, 16, 4, 1, 0, 0, 0, 0, 16, 16};

	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (capture_event_q === 1'b1) ev_cnt++;

	icc_src_model #(.TW(16)) i_src (.core_clk(core_clk), .peripheral_clock(src_p), .timer_one_clock(src_1),
		.timer_two_clock(src_2), .timer_three_clock(src_3), .timer_four_clock(src_4), .timer_five_clock(src_5));
	icc_top #(.DEPTH(4), .TW(16)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.capture_channel(capture_channel), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
		.peripheral_clock(src_p), .timer_one_clock(src_1), .timer_two_clock(src_2),
		.timer_three_clock(src_3), .timer_four_clock(src_4), .timer_five_clock(src_5),
		.capture_event_q(capture_event_q), .irq_q(irq_q));

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic expect_rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		`CHK(rv, e)
	endtask

	task automatic pin(input logic v);
		@(posedge core_clk);
		capture_channel <= v;
		repeat (5) @(posedge core_clk);
	endtask

	// draining pops one word per pulse; capture events count whether or not the fifo is full
	task automatic pulses(input int n, input bit drain);
		for (int i = 0; i < n; i++)
		begin
			pin(1'b1);
			if (drain)
				expect_rd(`ICC_ADDR_DATA, 16'h3333);
			pin(1'b0);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#400000;
		error_cnt++;
		close_out();
	end

	initial
	begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		expect_rd(`ICC_ADDR_CTRL, 16'h0000);
		expect_rd(`ICC_ADDR_IRQ_STAT, 16'h0000);
		wr(`ICC_ADDR_CTRL, 16'hFFFF);
		expect_rd(`ICC_ADDR_CTRL, 16'h3C67);
		wr(4'hF, 16'hFFFF);
		expect_rd(4'hF, 16'h0000);
		$display("register test done");
		for (int i = 0; i < 8; i++)
		begin
			wr(`ICC_ADDR_CTRL, {3'h0, ts[i], 10'h002});
			pin(1'b1);
			expect_rd(`ICC_ADDR_CTRL, {3'h0, ts[i], 10'h00A});
			expect_rd(`ICC_ADDR_DATA, tv[i]);
			pin(1'b0);
			expect_rd(`ICC_ADDR_CTRL, {3'h0, ts[i], 10'h002});
		end
		$display("timebase test done");
		// prescaled rows push too rarely to feed a read per pulse, so only the single-edge modes drain
		for (int i = 0; i < 15; i++)
		begin
			wr(`ICC_ADDR_CTRL, cv[i]);
			{cpu_idle, cpu_sleep} <= pw[i];
			ev_cnt = 0;
			pulses(16, ex[i] != 0 && (cv[i][2:0] == 3'h2 || cv[i][2:0] == 3'h3));
			`CHK(ev_cnt, ex[i])
		end
		{cpu_idle, cpu_sleep} <= 2'h0;
		expect_rd(`ICC_ADDR_IRQ_STAT, 16'h0007);
		$display("mode test done");
		wr(`ICC_ADDR_CTRL, 16'h0002);
		pulses(5, 1'b0);
		expect_rd(`ICC_ADDR_CTRL, 16'h001A);
		expect_rd(`ICC_ADDR_IRQ_STAT, 16'h0003);
		for (int i = 0; i < 4; i++)
			expect_rd(`ICC_ADDR_DATA, 16'h3333);
		expect_rd(`ICC_ADDR_DATA, 16'h0000);
		expect_rd(`ICC_ADDR_CTRL, 16'h0002);
		$display("overflow test done");
		wr(`ICC_ADDR_IRQ_MASK, 16'h0001);
		expect_rd(`ICC_ADDR_IRQ_MASK, 16'h0001);
		pulses(1, 1'b0);
		#1 `CHK(irq_q, 1'b1)
		wr(`ICC_ADDR_IRQ_MASK, 16'h0000);
		@(posedge core_clk);
		#1 `CHK(irq_q, 1'b0)
		wr(`ICC_ADDR_IRQ_MASK, 16'h0001);
		@(posedge core_clk);
		#1 `CHK(irq_q, 1'b1)
		expect_rd(`ICC_ADDR_IRQ_STAT, 16'h0001);
		@(posedge core_clk);
		#1 `CHK(irq_q, 1'b0)
		$display("interrupt test done");
		close_out();
	end
endmodule
